// >>> design/tmr_byte_cnt.sv
`timescale 1ns/1ps
// ==========================================================
// byte counter: held at zero while stopped
// ==========================================================
module tmr_byte_cnt (
  input  wire logic clock,
  input  wire logic rst_n,
  tmr_cnt_if.cnt    port
);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port.count <= tmr_pkg::RST_BYTE;             // [R23]
    end else if (!port.run || port.clr) begin
      port.count <= tmr_pkg::BYTE_ZERO;            // [R9] [R10]
    end else if (port.inc) begin
      port.count <= port.count + tmr_pkg::BYTE_ONE;
    end
  end

  // buffer follows reload while stopped, and refreshes only while the count sits at zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port.match_buf <= tmr_pkg::RST_BYTE;         // [R23]
    end else if (!port.run || port.count == tmr_pkg::BYTE_ZERO) begin
      port.match_buf <= port.reload;               // [R7]
    end
  end
endmodule

// >>> design/tmr_cnt_if.sv
`timescale 1ns/1ps
// ==========================================================
// one byte counter with its match buffer
// ==========================================================
interface tmr_cnt_if;
  logic       run;
  logic       inc;
  logic       clr;
  logic [7:0] reload;
  logic [7:0] count;
  logic [7:0] match_buf;

  modport ctl (output run, output inc, output clr, output reload, input count, input match_buf);
  modport cnt (input run, input inc, input clr, input reload, output count, output match_buf);
endinterface

// >>> design/tmr_pkg.sv
package tmr_pkg;

  // ==========================================================
  // register indices; byte address is four times the index
  // ==========================================================
  localparam logic [15:0] IDX_LOW_RELOAD   = 16'h7f14;
  localparam logic [15:0] IDX_HIGH_RELOAD  = 16'h7f15;
  localparam logic [15:0] IDX_CONTROL      = 16'h7f16;
  localparam logic [15:0] IDX_DIVIDER      = 16'h7f17;
  localparam logic [15:0] IDX_LOW_CAPTURE  = 16'h7f18;
  localparam logic [15:0] IDX_HIGH_CAPTURE = 16'h7f19;
  localparam logic [15:0] IDX_LOW_COUNT    = 16'h7f1a;
  localparam logic [15:0] IDX_HIGH_COUNT   = 16'h7f1b;

  // ==========================================================
  // timer_control fields
  // ==========================================================
  localparam int CTL_HIGH_COUNT_ENABLE   = 7;
  localparam int CTL_HIGH_MATCH_FLAG   = 6;
  localparam int CTL_HIE    = 5;
  localparam int CTL_SRC_HI = 4;
  localparam int CTL_SRC_LO = 3;
  localparam int CTL_RUN    = 2;
  localparam int CTL_FLG    = 1;
  localparam int CTL_IE     = 0;

  // ==========================================================
  // divider_and_mode_control fields
  // ==========================================================
  localparam int DIV_RDSEL  = 7;
  localparam int DIV_LEN8   = 6;
  localparam int DIV_CAPEN  = 5;
  localparam int DIV_LIM_HI = 4;

  // ==========================================================
  // reset values and encodings
  // ==========================================================
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [4:0]  RST_PRESCALE = 5'h00;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [7:0]  BYTE_ONE     = 8'h01;
  localparam logic [7:0]  BYTE_FULL    = 8'hff;
  localparam logic [4:0]  PRESCALE_ONE = 5'h01;

  localparam logic [1:0] SRC_SYSTEM = 2'h0;
  localparam logic [1:0] SRC_RC     = 2'h1;
  localparam logic [1:0] SRC_SLOW   = 2'h2;
  localparam logic [1:0] SRC_FAST   = 2'h3;

  localparam logic       HRESP_OKAY = 1'h0;

  typedef enum logic [1:0] {
    TMR_BUS_IDLE,
    TMR_BUS_WRITE,
    TMR_BUS_READ,
    TMR_BUS_RDONE
  } tmr_bus_state_t;

endpackage

// >>> design/tmr_sync_edge.sv
`timescale 1ns/1ps
// ==========================================================
// two-flop synchroniser with rising edge pulse
// ==========================================================
module tmr_sync_edge (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      rise
);
  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // edge taken between second and third flops only
  assign rise = stage2 & ~stage3;
endmodule

// >>> design/tmr_timer.sv
`timescale 1ns/1ps
// Operation
// R1 - select prescaler source: system, RC, slow, fast
// R2 - prescaler match at limit, clears; stop clears
// R3 - run bit starts prescaler and low counter
// R4 - low advances on prescale match; 16-bit full match
// R5 - length bit: high counts overflow or clock
// R6 - high runs by run or high enable
// R7 - buffer tracks reload stopped, loads at zero
// R8 - software writes reload once per match period
// R9 - clearing run holds zero, buffer equals reload
// R10 - clearing high enable holds high at zero
// R11 - main flag sets when count returns zero
// R12 - high flag sets when high counter wraps
// R13 - flags stay set until software writes zero
// R14 - main enable and flag request interrupt
// R15 - high enable and high flag request interrupt
// R16 - capture only when capture enable set
// R17 - 16-bit: both bytes captured on high flag
// R18 - 8-bit: bytes captured on opposite flags
// R19 - readback select shows captures at reload addresses
// R20 - period is reload+1 times limit+1 ticks
// R21 - software reads capture while condition holds
// R22 - low overflow advances high counter in 16-bit
// R23 - everything clears to zero at reset
module tmr_timer (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        rc_osc_clock,
  input  wire logic        slow_crystal_clock,
  input  wire logic        fast_ceramic_clock,
  output logic             timer_irq
);

  // ==========================================================
  // register state
  // ==========================================================
  logic [7:0] low_reload_value;
  logic [7:0] high_reload_value;
  logic [7:0] timer_control;
  logic [7:0] divider_and_mode_control;
  logic [7:0] low_capture_value;
  logic [7:0] high_capture_value;

  tmr_cnt_if lo_if ();
  tmr_cnt_if hi_if ();

  logic       high_count_enable;
  logic       high_match_flag;
  logic       high_irq_enable;
  logic [1:0] count_source_select;
  logic       run;
  logic       main_match_flag;
  logic       main_irq_enable;
  logic       readback_select;
  logic       counter_length_select;
  logic       capture_enable;
  logic [4:0] divider_limit;

  assign high_count_enable     = timer_control[tmr_pkg::CTL_HIGH_COUNT_ENABLE];
  assign high_match_flag       = timer_control[tmr_pkg::CTL_HIGH_MATCH_FLAG];
  assign high_irq_enable       = timer_control[tmr_pkg::CTL_HIE];
  assign count_source_select   = timer_control[tmr_pkg::CTL_SRC_HI:tmr_pkg::CTL_SRC_LO];
  assign run                   = timer_control[tmr_pkg::CTL_RUN];
  assign main_match_flag       = timer_control[tmr_pkg::CTL_FLG];
  assign main_irq_enable       = timer_control[tmr_pkg::CTL_IE];
  assign readback_select       = divider_and_mode_control[tmr_pkg::DIV_RDSEL];
  assign counter_length_select = divider_and_mode_control[tmr_pkg::DIV_LEN8];
  assign capture_enable        = divider_and_mode_control[tmr_pkg::DIV_CAPEN];
  assign divider_limit         = divider_and_mode_control[tmr_pkg::DIV_LIM_HI:0];

  // ==========================================================
  // bus slave: zero-wait writes, one wait state on reads
  // ==========================================================
  tmr_pkg::tmr_bus_state_t bus_state;
  tmr_pkg::tmr_bus_state_t next_bus_state;
  logic [15:0]             dp_index;
  logic                    dp_mapped;
  logic                    accept;
  logic                    addr_hit;
  logic                    wr_en;
  logic [7:0]              rd_value;

  assign accept   = hsel & hready & htrans[1];
  assign addr_hit = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
  assign wr_en    = (bus_state == tmr_pkg::TMR_BUS_WRITE) & dp_mapped;

  always_comb begin
    next_bus_state = tmr_pkg::TMR_BUS_IDLE;
    case (bus_state)
      tmr_pkg::TMR_BUS_READ: next_bus_state = tmr_pkg::TMR_BUS_RDONE;
      tmr_pkg::TMR_BUS_IDLE,
      tmr_pkg::TMR_BUS_WRITE,
      tmr_pkg::TMR_BUS_RDONE: begin
        if (accept) begin
          next_bus_state = hwrite ? tmr_pkg::TMR_BUS_WRITE : tmr_pkg::TMR_BUS_READ;
        end
      end
      default: next_bus_state = tmr_pkg::TMR_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= tmr_pkg::TMR_BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dp_index  <= 16'h0000;
      dp_mapped <= 1'b0;
    end else if (accept) begin
      dp_index  <= haddr[17:2];
      dp_mapped <= addr_hit;
    end
  end

  // read data is taken a cycle late so a write just before it is already visible
  always_comb begin
    rd_value = tmr_pkg::BYTE_ZERO;
    if (dp_mapped) begin
      case (dp_index)
        tmr_pkg::IDX_LOW_RELOAD:   rd_value = readback_select ? low_capture_value : low_reload_value;   // [R19]
        tmr_pkg::IDX_HIGH_RELOAD:  rd_value = readback_select ? high_capture_value : high_reload_value; // [R19]
        tmr_pkg::IDX_CONTROL:      rd_value = timer_control;
        tmr_pkg::IDX_DIVIDER:      rd_value = divider_and_mode_control;
        tmr_pkg::IDX_LOW_CAPTURE:  rd_value = low_capture_value;
        tmr_pkg::IDX_HIGH_CAPTURE: rd_value = high_capture_value;
        tmr_pkg::IDX_LOW_COUNT:    rd_value = lo_if.count;
        tmr_pkg::IDX_HIGH_COUNT:   rd_value = hi_if.count;
        default:                   rd_value = tmr_pkg::BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= tmr_pkg::RST_WORD;
    end else if (bus_state == tmr_pkg::TMR_BUS_READ) begin
      hrdata <= {24'h00_0000, rd_value};
    end
  end

  assign hreadyout = (bus_state != tmr_pkg::TMR_BUS_READ);
  assign hresp     = tmr_pkg::HRESP_OKAY;

  // ==========================================================
  // count source and prescaler
  // ==========================================================
  logic       rc_rise;
  logic       slow_rise;
  logic       fast_rise;
  logic       src_tick;
  logic [4:0] prescale;
  logic       pre_match;

  tmr_sync_edge u_sync_rc (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (rc_osc_clock),
    .rise  (rc_rise)
  );
  tmr_sync_edge u_sync_slow (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (slow_crystal_clock),
    .rise  (slow_rise)
  );
  tmr_sync_edge u_sync_fast (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (fast_ceramic_clock),
    .rise  (fast_rise)
  );

  // oscillator inputs must stay below half the system clock to be seen
  always_comb begin
    case (count_source_select)                       // [R1]
      tmr_pkg::SRC_SYSTEM: src_tick = 1'b1;
      tmr_pkg::SRC_RC:     src_tick = rc_rise;
      tmr_pkg::SRC_SLOW:   src_tick = slow_rise;
      tmr_pkg::SRC_FAST:   src_tick = fast_rise;
      default:             src_tick = 1'b0;
    endcase
  end

  assign pre_match = run & src_tick & (prescale == divider_limit);   // [R2]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= tmr_pkg::RST_PRESCALE;             // [R23]
    end else if (!run || pre_match) begin
      prescale <= tmr_pkg::RST_PRESCALE;             // [R2] [R3]
    end else if (src_tick) begin
      prescale <= prescale + tmr_pkg::PRESCALE_ONE;
    end
  end

  // ==========================================================
  // byte counters
  // ==========================================================
  logic full_match;
  logic lo_match;
  logic hi_match;
  logic lo_overflow;
  logic main_event;
  logic high_event;

  // period = (reload + 1) x (limit + 1) source ticks; high in 8-bit = reload + 1 cycles   [R20]
  assign full_match  = pre_match &&
                       ({hi_if.count, lo_if.count} == {hi_if.match_buf, lo_if.match_buf});   // [R4]
  assign lo_match    = pre_match && (lo_if.count == lo_if.match_buf);                       // [R4]
  assign lo_overflow = pre_match && (lo_if.count == tmr_pkg::BYTE_FULL);                     // [R22]
  assign hi_match    = hi_if.run && (hi_if.count == hi_if.match_buf);

  assign lo_if.run    = run;                                                  // [R3]
  assign lo_if.inc    = pre_match;                                            // [R4]
  assign lo_if.clr    = counter_length_select ? lo_match : full_match;
  assign lo_if.reload = low_reload_value;

  assign hi_if.run    = counter_length_select ? high_count_enable : run;      // [R6]
  assign hi_if.inc    = counter_length_select ? 1'b1 : lo_overflow;           // [R5] [R22]
  assign hi_if.clr    = counter_length_select ? hi_match : full_match;        // [R5]
  assign hi_if.reload = high_reload_value;

  assign main_event = counter_length_select ? lo_match : full_match;          // [R11]
  assign high_event = counter_length_select & hi_match;                       // [R12]

  tmr_byte_cnt u_low (
    .clock (clock),
    .rst_n (rst_n),
    .port  (lo_if.cnt)
  );
  tmr_byte_cnt u_high (
    .clock (clock),
    .rst_n (rst_n),
    .port  (hi_if.cnt)
  );

  // ==========================================================
  // software registers and flags
  // ==========================================================
  logic       wr_control;
  logic       next_main_flag;
  logic       next_high_flag;
  logic       main_flag_rise;
  logic       high_flag_rise;

  assign wr_control = wr_en && (dp_index == tmr_pkg::IDX_CONTROL);

  // a hardware event in the same cycle as a clearing write keeps the flag set
  assign next_main_flag = main_event | (wr_control ? hwdata[tmr_pkg::CTL_FLG] : main_match_flag);  // [R11] [R13]
  assign next_high_flag = high_event | (wr_control ? hwdata[tmr_pkg::CTL_HIGH_MATCH_FLAG] : high_match_flag); // [R12] [R13]
  assign main_flag_rise = next_main_flag & ~main_match_flag;
  assign high_flag_rise = next_high_flag & ~high_match_flag;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_control <= tmr_pkg::RST_BYTE;            // [R23]
    end else begin
      if (wr_control) begin
        timer_control <= hwdata[7:0];
      end
      timer_control[tmr_pkg::CTL_FLG]  <= next_main_flag;
      timer_control[tmr_pkg::CTL_HIGH_MATCH_FLAG] <= next_high_flag;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_reload_value         <= tmr_pkg::RST_BYTE;
      high_reload_value        <= tmr_pkg::RST_BYTE;
      divider_and_mode_control <= tmr_pkg::RST_BYTE;
    end else if (wr_en) begin
      if (dp_index == tmr_pkg::IDX_LOW_RELOAD) begin
        low_reload_value <= hwdata[7:0];
      end
      if (dp_index == tmr_pkg::IDX_HIGH_RELOAD) begin
        high_reload_value <= hwdata[7:0];
      end
      if (dp_index == tmr_pkg::IDX_DIVIDER) begin
        divider_and_mode_control <= hwdata[7:0];
      end
    end
  end

  // ==========================================================
  // capture: counts as they stand when the trigger flag rises
  // ==========================================================
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_capture_value <= tmr_pkg::RST_BYTE;        // [R23]
    end else if (capture_enable && high_flag_rise) begin
      low_capture_value <= lo_if.count;              // [R16] [R17] [R18]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      high_capture_value <= tmr_pkg::RST_BYTE;       // [R23]
    end else if (capture_enable && (counter_length_select ? main_flag_rise : high_flag_rise)) begin
      high_capture_value <= hi_if.count;             // [R16] [R17] [R18]
    end
  end

  assign timer_irq = (main_irq_enable & main_match_flag) | (high_irq_enable & high_match_flag);   // [R14] [R15]

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_high_rise_16;
    capture_enable && !counter_length_select && !high_match_flag ##1 high_match_flag;
  endsequence
  sequence s_main_rise_8;
    capture_enable && counter_length_select && !main_match_flag ##1 main_match_flag;
  endsequence

  a_prescale_wrap: assert property (pre_match |=> prescale == tmr_pkg::RST_PRESCALE) // [R2]
    else $error("prescaler did not return to zero on match");
  a_prescale_step: assert property (run && src_tick && !pre_match && $stable(run)
    |=> prescale == $past(prescale) + tmr_pkg::PRESCALE_ONE) // [R3]
    else $error("prescaler did not advance on a tick");
  a_stop_reload: assert property (!run ##1 !run |-> lo_if.count == tmr_pkg::BYTE_ZERO
    && lo_if.match_buf == $past(low_reload_value)) // [R9]
    else $error("stopped low counter not at zero with buffer equal reload");
  a_high_stop: assert property (counter_length_select && !high_count_enable
    ##1 counter_length_select && !high_count_enable |-> hi_if.count == tmr_pkg::BYTE_ZERO) // [R10]
    else $error("high counter not held at zero");
  a_high_wrap: assert property (counter_length_select && hi_match && !wr_en |=> hi_if.count == tmr_pkg::BYTE_ZERO
    && high_match_flag) // [R12]
    else $error("high counter match did not wrap and flag");
  a_main_flag: assert property (main_event |=> main_match_flag) // [R11]
    else $error("main flag not set on return to zero");
  a_flag_sticky: assert property (main_match_flag && !wr_control |=> main_match_flag) // [R13]
    else $error("main flag cleared without a software write");
  a_irq_main: assert property (main_irq_enable && main_event && !wr_control |=> timer_irq) // [R14]
    else $error("missing interrupt for main match");
  a_irq_high: assert property (high_irq_enable && high_event && !wr_control |=> timer_irq) // [R15]
    else $error("missing interrupt for high match");
  a_capture_off: assert property (!capture_enable |=> $stable(low_capture_value)
    && $stable(high_capture_value)) // [R16]
    else $error("capture changed while disabled");
  a_capture_both: assert property (s_high_rise_16 |-> low_capture_value == $past(lo_if.count)
    && high_capture_value == $past(hi_if.count)) // [R17]
    else $error("16-bit capture missed a byte");
  a_capture_high8: assert property (s_main_rise_8 |-> high_capture_value == $past(hi_if.count)) // [R18]
    else $error("8-bit high capture missed");
  a_read_capture: assert property (bus_state == tmr_pkg::TMR_BUS_READ && dp_mapped && readback_select
    && dp_index == tmr_pkg::IDX_LOW_RELOAD |=> hrdata[7:0] == $past(low_capture_value)) // [R19]
    else $error("readback select did not return the capture");

endmodule

// >>> testbench/tmr_timer_tb_top.sv
`timescale 1ns/1ps
module tmr_timer_tb_top;
  logic        clock     = 1'b0;
  logic        rst_n     = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0000_0000;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0000_0000;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        timer_irq;
  logic [3:0]  osc       = 4'h0;
  logic [31:0] rd;
  int          mismatches = 0;
  int          tests_run  = 0;
  int          cyc        = 0;
  int          t1;
  logic [7:0]  ctls [4]   = '{8'h05, 8'h0d, 8'h15, 8'h1d};
  int          exps [4]   = '{4, 16, 64, 32};

  tmr_timer dut_u (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .rc_osc_clock(osc[1]), .slow_crystal_clock(osc[3]),
    .fast_ceramic_clock(osc[2]), .timer_irq(timer_irq));

  // ==========================================================
  // clock and free-running oscillators (rc /4, fast /8, slow /16)
  // ==========================================================
  initial begin
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    osc <= osc + 4'h1;
    cyc <= cyc + 1;
  end

  // ==========================================================
  // bus tasks
  // ==========================================================
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) check("hreadyout", 32'h0000_0001, 32'h0000_0000);
  endtask

  // address phase held until ready, then data phase held until ready
  task automatic xfer(input logic [15:0] idx, input logic wr_en, input logic [7:0] val);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr_en;
    haddr  <= {14'h0, idx, 2'h0};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, val};
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] val);
    xfer(idx, 1'b1, val);
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp, input string name);
    xfer(idx, 1'b0, 8'h00);
    check(name, {24'h0, exp}, rd);
    check("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (timer_irq !== 1'b1 && n < lim);
    if (n >= lim) check("timer_irq", 32'h0000_0001, 32'h0000_0000);
  endtask

  // start with ctl, time two request rises; software clears in between
  task automatic period(input logic [7:0] ctl, input int exp, input string name);
    wr(tmr_pkg::IDX_CONTROL, ctl);
    wait_irq(2000);
    t1 = cyc;
    wr(tmr_pkg::IDX_CONTROL, ctl);
    wait_irq(2000);
    check(name, 32'(exp), 32'(cyc - t1));
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  // ==========================================================
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check("irq after reset", 32'h0000_0000, {31'h0, timer_irq});
    for (int i = 0; i < 8; i++) begin
      rd_chk(tmr_pkg::IDX_LOW_RELOAD + 16'(i), 8'h00, "reset value");
    end
    wr(16'h7f1c, 8'h5a);
    rd_chk(16'h7f1c, 8'h00, "unmapped");
    wr(tmr_pkg::IDX_LOW_RELOAD, 8'ha5);
    wr(tmr_pkg::IDX_HIGH_RELOAD, 8'h3c);
    rd_chk(tmr_pkg::IDX_LOW_RELOAD, 8'ha5, "low reload");
    rd_chk(tmr_pkg::IDX_HIGH_RELOAD, 8'h3c, "high reload");
    wr(tmr_pkg::IDX_DIVIDER, 8'h80);
    rd_chk(tmr_pkg::IDX_LOW_RELOAD, 8'h00, "low capture view");
    rd_chk(tmr_pkg::IDX_HIGH_RELOAD, 8'h00, "high capture view");
    // 16-bit: reload 0x0201, limit 1 -> (513+1)*(1+1) cycles, high fed by low roll
    wr(tmr_pkg::IDX_DIVIDER, 8'h01);
    wr(tmr_pkg::IDX_LOW_RELOAD, 8'h01);
    wr(tmr_pkg::IDX_HIGH_RELOAD, 8'h02);
    period(8'h05, 1028, "16-bit period");
    repeat (100) @(posedge clock);
    rd_chk(tmr_pkg::IDX_CONTROL, 8'h07, "main flag held");
    check("main irq", 32'h0000_0001, {31'h0, timer_irq});
    wr(tmr_pkg::IDX_CONTROL, 8'h01);
    @(posedge clock);
    check("irq masked by flag clear", 32'h0000_0000, {31'h0, timer_irq});
    rd_chk(tmr_pkg::IDX_LOW_COUNT, 8'h00, "low stopped");
    rd_chk(tmr_pkg::IDX_HIGH_COUNT, 8'h00, "high stopped");
    // 8-bit low: reload 3, limit 0 -> 4 source ticks per period
    wr(tmr_pkg::IDX_DIVIDER, 8'h40);
    wr(tmr_pkg::IDX_LOW_RELOAD, 8'h03);
    for (int i = 0; i < 4; i++) begin
      wr(tmr_pkg::IDX_CONTROL, 8'h00);
      period(ctls[i], exps[i], "source period");
    end
    wr(tmr_pkg::IDX_CONTROL, 8'h00);
    // 8-bit high with main run off: reload 7 -> 8 system clocks
    wr(tmr_pkg::IDX_HIGH_RELOAD, 8'h07);
    period(8'ha0, 8, "high period");
    wr(tmr_pkg::IDX_CONTROL, 8'h00);
    rd_chk(tmr_pkg::IDX_HIGH_COUNT, 8'h00, "high held");
    // capture of the high count on a software-set main flag
    wr(tmr_pkg::IDX_HIGH_RELOAD, 8'hff);
    wr(tmr_pkg::IDX_CONTROL, 8'h80);
    t1 = cyc;
    wr(tmr_pkg::IDX_CONTROL, 8'h82);
    wr(tmr_pkg::IDX_DIVIDER, 8'hc0);
    rd_chk(tmr_pkg::IDX_HIGH_RELOAD, 8'h00, "capture disabled");
    wr(tmr_pkg::IDX_CONTROL, 8'h80);
    wr(tmr_pkg::IDX_DIVIDER, 8'he0);
    wr(tmr_pkg::IDX_CONTROL, 8'h82);
    // high counts one per clock since enable; capture takes the count of the cycle the flag rises
    t1 = cyc - t1 - 1;
    rd_chk(tmr_pkg::IDX_HIGH_RELOAD, 8'(t1), "8-bit high capture");
    // 16-bit: a software-set high flag captures both bytes at once
    wr(tmr_pkg::IDX_CONTROL, 8'h00);
    wr(tmr_pkg::IDX_DIVIDER, 8'ha0);
    wr(tmr_pkg::IDX_CONTROL, 8'h04);
    t1 = cyc;
    wr(tmr_pkg::IDX_CONTROL, 8'h44);
    t1 = cyc - t1 - 1;
    rd_chk(tmr_pkg::IDX_LOW_RELOAD, 8'(t1), "16-bit low capture");
    rd_chk(tmr_pkg::IDX_HIGH_RELOAD, 8'h00, "16-bit high capture");
    wrap_up();
  end

  // the full sequence needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    wrap_up();
  end
endmodule
